// File: pkg/lfa_pkg.sv
// Constants and types for the long floating arithmetic unit
package lfa_pkg;
	localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
	localparam logic [31:0] ADDR_PRI_LO    = 32'h0000_0004;
	localparam logic [31:0] ADDR_PRI_HI    = 32'h0000_0008;
	localparam logic [31:0] ADDR_NXT_LO    = 32'h0000_000c;
	localparam logic [31:0] ADDR_NXT_HI    = 32'h0000_0010;
	localparam logic [31:0] ADDR_MEM_LO    = 32'h0000_0014;
	localparam logic [31:0] ADDR_MEM_HI    = 32'h0000_0018;
	localparam logic [31:0] ADDR_STAT      = 32'h0000_001c;

	localparam int          CTRL_START_BIT = 9;
	localparam int          CTRL_TWOS_BIT  = 10;
	localparam int          STAT_BUSY_BIT  = 8;

	localparam logic [8:0]  OP_ADD_LONG    = 9'h061;
	localparam logic [8:0]  OP_SUB_LONG    = 9'h069;
	localparam logic [8:0]  OP_MUL_LONG    = 9'h071;
	localparam logic [8:0]  OP_DIV_LONG    = 9'h079;
	localparam logic [8:0]  CTRL_OP_RST    = 9'h000;
	localparam logic [35:0] WORD_RST       = 36'h0;

	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [2:0]  HSIZE_WORD     = 3'h2;
	localparam logic        HRESP_OKAY     = 1'b0;

	typedef logic signed [11:0] lfa_exp_t;

	localparam lfa_exp_t    EXP_BIAS       = 12'sh080;
	localparam lfa_exp_t    EXP_MAX        = 12'sh07f;
	localparam lfa_exp_t    EXP_MIN        = -12'sh080;
	localparam lfa_exp_t    LOW_MIN        = -12'sh065;
	localparam lfa_exp_t    MUL_LOW_MAX    = 12'sh09a;
	localparam lfa_exp_t    LOW_EXP_OFS    = 12'sh01b;
	localparam lfa_exp_t    REM_OFS_GE     = 12'sh01a;
	localparam lfa_exp_t    REM_OFS_LT     = 12'sh01b;

	typedef enum logic [1:0] {
		LFA_IDLE = 2'b00,
		LFA_EXEC = 2'b01
	} lfa_state_t;

	typedef struct packed {
		logic trap1;
		logic ovf;
		logic fov;
		logic fuf;
		logic nodiv;
	} lfa_flags_t;

	typedef struct packed {
		logic        sign;
		lfa_exp_t    exp;
		logic [53:0] frac;
	} lfa_num_t;
endpackage : lfa_pkg

// File: logic/lfa_unit.sv
// Long floating add, subtract, multiply and divide unit behind an AHB-Lite slave
`timescale 1ns/10ps
module lfa_unit (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp
);
	lfa_pkg::lfa_state_t state,     next_state;
	lfa_pkg::lfa_flags_t flags,     next_flags;
	logic [8:0]          ctrl_op,   next_ctrl_op;
	logic                ctrl_twos, next_ctrl_twos;
	logic [35:0]         pri,       next_pri;
	logic [35:0]         nxt,       next_nxt;
	logic [35:0]         mem,       next_mem;
	logic [35:0]         opa,       next_opa;
	logic [35:0]         opn,       next_opn;
	logic [35:0]         opm,       next_opm;
	logic [8:0]          opl,       next_opl;
	logic                twos,      next_twos;
	logic                wr_pend,   next_wr_pend;
	logic [31:0]         wr_addr,   next_wr_addr;
	logic [31:0]         hrdata,    next_hrdata;
	logic                start;

	lfa_pkg::lfa_num_t   ua, ub, ud, nn, qn, chk_pri;
	lfa_pkg::lfa_flags_t dp_set;
	lfa_pkg::lfa_exp_t   sh, rexp0, lowexp, qexp, rexp, dp_exp;
	logic [5:0]          shc;
	logic [53:0]         ma, mb, prod, quo, rem;
	logic [57:0]         xa, xb, sum, smag;
	logic [55:0]         rmag;
	logic [62:0]         word, qpos, rword;
	logic [35:0]         qhi, qword, dp_pri, dp_nxt;
	logic [27:0]         dden;
	logic [26:0]         dvs, q, rfrac;
	logic                big, bsign, rsign, fail, ge, qneg, remz;
	logic                dp_wp, dp_wn, dp_zero, dp_fail, dp_lowclr, dp_remclr;

	function automatic lfa_pkg::lfa_num_t f_unpack(input logic [62:0] s);
		logic [62:0]       m;
		lfa_pkg::lfa_num_t r;
		m = s[62] ? (~s + 63'h1) : s;
		r.sign = s[62];
		r.exp = $signed({4'h0, m[61:54]}) - lfa_pkg::EXP_BIAS;
		r.frac = m[53:0];
		return r;
	endfunction : f_unpack

	// Truncates instead of rounding; the low bits simply fall away
	function automatic lfa_pkg::lfa_num_t f_norm(input logic [55:0] m, input lfa_pkg::lfa_exp_t e);
		logic [55:0]       t;
		lfa_pkg::lfa_num_t r;
		t = m;
		r.exp = e;
		r.sign = 1'b0;
		if (t[55]) begin
			t = t >> 2;
			r.exp = r.exp + 12'sh002;
		end else if (t[54]) begin
			t = t >> 1;
			r.exp = r.exp + 12'sh001;
		end
		for (int i = 0; i < 54; i++) begin
			if (!t[53]) begin
				t = t << 1;
				r.exp = r.exp - 12'sh001;
			end
		end
		r.frac = t[53:0];
		return r;
	endfunction : f_norm

	// Exponent field keeps only eight bits, which gives the 256 wrap
	function automatic logic [62:0] f_pack(input logic sg, input lfa_pkg::lfa_exp_t e, input logic [53:0] f);
		lfa_pkg::lfa_exp_t b;
		logic [62:0]       w;
		b = e + lfa_pkg::EXP_BIAS;
		w = {1'b0, b[7:0], f};
		return sg ? (~w + 63'h1) : w;
	endfunction : f_pack

	function automatic lfa_pkg::lfa_flags_t f_range(input lfa_pkg::lfa_exp_t e);
		lfa_pkg::lfa_flags_t r;
		r = '0;
		r.ovf = (e > lfa_pkg::EXP_MAX) || (e < lfa_pkg::EXP_MIN);
		r.trap1 = r.ovf;
		r.fov = r.ovf;
		r.fuf = e < lfa_pkg::EXP_MIN;
		return r;
	endfunction : f_range

	always_comb begin
		ua = f_unpack({opa, 27'h0});
		ub = f_unpack({opm, 27'h0});
		ud = f_unpack({opa, opn[26:0]});
		dp_set = '0;
		dp_wp = 1'b0;
		dp_wn = 1'b0;
		dp_pri = lfa_pkg::WORD_RST;
		dp_nxt = lfa_pkg::WORD_RST;
		dp_exp = '0;
		dp_zero = 1'b0;
		dp_fail = 1'b0;
		dp_lowclr = 1'b0;
		dp_remclr = 1'b0;
		bsign = ub.sign ^ (opl == lfa_pkg::OP_SUB_LONG);
		big = ua.exp >= ub.exp;
		sh = big ? (ua.exp - ub.exp) : (ub.exp - ua.exp);
		shc = (sh > 12'sh039) ? 6'h39 : sh[5:0];
		ma = big ? ua.frac : (ua.frac >> shc);
		mb = big ? (ub.frac >> shc) : ub.frac;
		xa = ua.sign ? (~{4'h0, ma} + 58'h1) : {4'h0, ma};
		xb = bsign ? (~{4'h0, mb} + 58'h1) : {4'h0, mb};
		sum = xa + xb;
		smag = sum[57] ? (~sum + 58'h1) : sum;
		prod = ua.frac[53:27] * ub.frac[53:27];
		if (opl == lfa_pkg::OP_MUL_LONG) begin
			rsign = ua.sign ^ ub.sign;
			rmag = {2'h0, prod};
			rexp0 = ua.exp + ub.exp;
		end else begin
			rsign = sum[57];
			rmag = smag[55:0];
			rexp0 = big ? ua.exp : ub.exp;
		end
		nn = f_norm(rmag, rexp0);
		word = f_pack(rsign, nn.exp, nn.frac);
		lowexp = nn.exp - lfa_pkg::LOW_EXP_OFS + lfa_pkg::EXP_BIAS;
		dvs = ub.frac[53:27];
		fail = {1'b0, ud.frac} >= {dvs, 28'h0};
		ge = {1'b0, ud.frac} >= {1'b0, dvs, 27'h0};
		dden = ge ? {dvs, 1'b0} : {1'b0, dvs};
		// Divider is never used with a zero divisor, that case fails first
		quo = (dden == 28'h0) ? 54'h0 : (ud.frac / {26'h0, dden});
		rem = (dden == 28'h0) ? 54'h0 : (ud.frac % {26'h0, dden});
		q = (ud.frac[53:27] == 27'h0) ? 27'h0 : quo[26:0];
		qexp = ud.exp - ub.exp + (ge ? 12'sh001 : 12'sh000);
		qn = f_norm({2'h0, q, 27'h0}, qexp);
		qpos = f_pack(1'b0, qn.exp, qn.frac);
		qhi = qpos[62:27];
		remz = rem == 54'h0;
		qneg = ud.sign ^ ub.sign;
		if (!qneg) begin
			qword = qhi;
		end else if (remz || twos) begin
			qword = ~qhi + 36'h1;
		end else begin
			qword = ~qhi;
		end
		rexp = ud.exp - (ge ? lfa_pkg::REM_OFS_GE : lfa_pkg::REM_OFS_LT);
		rfrac = ge ? rem[27:1] : rem[26:0];
		rword = f_pack(ud.sign, rexp, {rfrac, 27'h0});
		case (opl)
			lfa_pkg::OP_ADD_LONG, lfa_pkg::OP_SUB_LONG, lfa_pkg::OP_MUL_LONG: begin
				dp_exp = nn.exp;
				dp_zero = rmag == 56'h0;
				dp_lowclr = (nn.exp < lfa_pkg::LOW_MIN) || (nn.frac[26:0] == 27'h0);
				if ((opl == lfa_pkg::OP_MUL_LONG) && (nn.exp > lfa_pkg::MUL_LOW_MAX)) begin
					dp_lowclr = 1'b1;
				end
				dp_wp = 1'b1;
				dp_wn = 1'b1;
				if (!dp_zero) begin
					dp_set = f_range(nn.exp);
					dp_pri = word[62:27];
					if (!dp_lowclr) begin
						dp_nxt = {1'b0, lowexp[7:0], word[26:0]};
					end
				end
			end
			lfa_pkg::OP_DIV_LONG: begin
				dp_fail = fail;
				if (fail) begin
					dp_set.trap1 = 1'b1;
					dp_set.ovf = 1'b1;
					dp_set.fov = 1'b1;
					dp_set.nodiv = 1'b1;
				end else begin
					dp_wp = 1'b1;
					dp_wn = 1'b1;
					dp_exp = qn.exp;
					dp_zero = q == 27'h0;
					dp_remclr = (rexp < lfa_pkg::EXP_MIN) || (rfrac == 27'h0);
					if (!dp_zero) begin
						dp_set = f_range(qn.exp);
						dp_pri = qword;
					end
					if (!dp_remclr) begin
						dp_nxt = rword[62:27];
					end
				end
			end
			default: begin
			end
		endcase
	end

	always_comb begin
		next_state = state;
		next_flags = flags;
		next_ctrl_op = ctrl_op;
		next_ctrl_twos = ctrl_twos;
		next_pri = pri;
		next_nxt = nxt;
		next_mem = mem;
		next_opa = opa;
		next_opn = opn;
		next_opm = opm;
		next_opl = opl;
		next_twos = twos;
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		next_hrdata = hrdata;
		start = 1'b0;
		// Operand registers are locked while a calculation is running
		if (wr_pend && (state == lfa_pkg::LFA_IDLE)) begin
			if (wr_addr == lfa_pkg::ADDR_CTRL) begin
				next_ctrl_op = i_hwdata[8:0];
				next_ctrl_twos = i_hwdata[lfa_pkg::CTRL_TWOS_BIT];
				start = i_hwdata[lfa_pkg::CTRL_START_BIT] && ((i_hwdata[8:0] == lfa_pkg::OP_ADD_LONG) ||
					(i_hwdata[8:0] == lfa_pkg::OP_SUB_LONG) || (i_hwdata[8:0] == lfa_pkg::OP_MUL_LONG) ||
					(i_hwdata[8:0] == lfa_pkg::OP_DIV_LONG));
			end else if (wr_addr == lfa_pkg::ADDR_PRI_LO) begin
				next_pri[31:0] = i_hwdata;
			end else if (wr_addr == lfa_pkg::ADDR_PRI_HI) begin
				next_pri[35:32] = i_hwdata[3:0];
			end else if (wr_addr == lfa_pkg::ADDR_NXT_LO) begin
				next_nxt[31:0] = i_hwdata;
			end else if (wr_addr == lfa_pkg::ADDR_NXT_HI) begin
				next_nxt[35:32] = i_hwdata[3:0];
			end else if (wr_addr == lfa_pkg::ADDR_MEM_LO) begin
				next_mem[31:0] = i_hwdata;
			end else if (wr_addr == lfa_pkg::ADDR_MEM_HI) begin
				next_mem[35:32] = i_hwdata[3:0];
			end
		end
		if (wr_pend && (wr_addr == lfa_pkg::ADDR_STAT)) begin
			next_flags = lfa_pkg::lfa_flags_t'(flags & ~i_hwdata[4:0]);
		end
		if (start) begin
			next_opa = pri;
			next_opn = nxt;
			next_opm = mem;
			next_opl = i_hwdata[8:0];
			next_twos = i_hwdata[lfa_pkg::CTRL_TWOS_BIT];
			next_state = lfa_pkg::LFA_EXEC;
		end
		if (state == lfa_pkg::LFA_EXEC) begin
			if (dp_wp) begin
				next_pri = dp_pri;
			end
			if (dp_wn) begin
				next_nxt = dp_nxt;
			end
			// Set wins over a clear in the same cycle
			next_flags = lfa_pkg::lfa_flags_t'(next_flags | dp_set);
			next_state = lfa_pkg::LFA_IDLE;
		end
		if (i_hsel && (i_htrans == lfa_pkg::HTRANS_NONSEQ) && i_hready) begin
			next_wr_pend = i_hwrite && (i_hsize == lfa_pkg::HSIZE_WORD);
			next_wr_addr = i_haddr;
			// Read from next values so a write just before is seen
			if (!i_hwrite) begin
				if (i_haddr == lfa_pkg::ADDR_CTRL) begin
					next_hrdata = {21'h0, next_ctrl_twos, 1'b0, next_ctrl_op};
				end else if (i_haddr == lfa_pkg::ADDR_PRI_LO) begin
					next_hrdata = next_pri[31:0];
				end else if (i_haddr == lfa_pkg::ADDR_PRI_HI) begin
					next_hrdata = {28'h0, next_pri[35:32]};
				end else if (i_haddr == lfa_pkg::ADDR_NXT_LO) begin
					next_hrdata = next_nxt[31:0];
				end else if (i_haddr == lfa_pkg::ADDR_NXT_HI) begin
					next_hrdata = {28'h0, next_nxt[35:32]};
				end else if (i_haddr == lfa_pkg::ADDR_MEM_LO) begin
					next_hrdata = next_mem[31:0];
				end else if (i_haddr == lfa_pkg::ADDR_MEM_HI) begin
					next_hrdata = {28'h0, next_mem[35:32]};
				end else if (i_haddr == lfa_pkg::ADDR_STAT) begin
					next_hrdata = {23'h0, next_state != lfa_pkg::LFA_IDLE, 3'h0, next_flags};
				end else begin
					next_hrdata = 32'h0;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= lfa_pkg::LFA_IDLE;
			flags <= '0;
			ctrl_op <= lfa_pkg::CTRL_OP_RST;
			ctrl_twos <= 1'b0;
			pri <= lfa_pkg::WORD_RST;
			nxt <= lfa_pkg::WORD_RST;
			mem <= lfa_pkg::WORD_RST;
			opa <= lfa_pkg::WORD_RST;
			opn <= lfa_pkg::WORD_RST;
			opm <= lfa_pkg::WORD_RST;
			opl <= lfa_pkg::CTRL_OP_RST;
			twos <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 32'h0;
			hrdata <= 32'h0;
		end else begin
			state <= next_state;
			flags <= next_flags;
			ctrl_op <= next_ctrl_op;
			ctrl_twos <= next_ctrl_twos;
			pri <= next_pri;
			nxt <= next_nxt;
			mem <= next_mem;
			opa <= next_opa;
			opn <= next_opn;
			opm <= next_opm;
			opl <= next_opl;
			twos <= next_twos;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	assign o_hrdata = hrdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = lfa_pkg::HRESP_OKAY;
	assign chk_pri = f_unpack({pri, 27'h0});

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	property p_capture;
		start |=> (state == lfa_pkg::LFA_EXEC) && (opa == $past(pri)) && (opm == $past(mem))
			##1 (state == lfa_pkg::LFA_IDLE);
	endproperty
	a_capture: assert property (p_capture) else $error("operands not captured before execution");
	property p_add_zero;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_ADD_LONG) && dp_zero |=> (pri == 36'h0) && (nxt == 36'h0);
	endproperty
	a_add_zero: assert property (p_add_zero) else $error("zero sum did not clear both registers");
	property p_add_norm;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_ADD_LONG) && !dp_zero |=> chk_pri.frac[53];
	endproperty
	a_add_norm: assert property (p_add_norm) else $error("sum high word not normalized");
	property p_add_low_clr;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_ADD_LONG) && !dp_zero && (dp_exp < lfa_pkg::LOW_MIN)
			|=> nxt == 36'h0;
	endproperty
	a_add_low_clr: assert property (p_add_low_clr) else $error("small sum exponent left next register");
	property p_low_fmt;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_ADD_LONG) && !dp_zero && !dp_lowclr
			|=> !nxt[35] && (nxt[34:27] == $past(lowexp[7:0]));
	endproperty
	a_low_fmt: assert property (p_low_fmt) else $error("low word format wrong");
	property p_sub_zero;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_SUB_LONG) && dp_zero |=> (pri == 36'h0) && (nxt == 36'h0);
	endproperty
	a_sub_zero: assert property (p_sub_zero) else $error("zero difference did not clear");
	property p_mul_clr;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_MUL_LONG) && !dp_zero && (dp_exp > lfa_pkg::MUL_LOW_MAX)
			|=> nxt == 36'h0;
	endproperty
	a_mul_clr: assert property (p_mul_clr) else $error("large product exponent left next register");
	property p_div_fail;
		(state == lfa_pkg::LFA_EXEC) && dp_fail |=> (pri == $past(pri)) && (nxt == $past(nxt))
			&& flags.nodiv && flags.trap1 && flags.ovf && flags.fov;
	endproperty
	a_div_fail: assert property (p_div_fail) else $error("failed divide altered registers or flags");
	property p_div_zero;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_DIV_LONG) && (opm[26:0] == 27'h0) |-> dp_fail;
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("zero divisor did not fail");
	property p_rem_clr;
		(state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_DIV_LONG) && !dp_fail && dp_remclr |=> nxt == 36'h0;
	endproperty
	a_rem_clr: assert property (p_rem_clr) else $error("remainder not cleared");
	property p_ovf;
		(state == lfa_pkg::LFA_EXEC) && !dp_zero && !dp_fail && (dp_exp > lfa_pkg::EXP_MAX)
			|=> flags.trap1 && flags.ovf && flags.fov;
	endproperty
	a_ovf: assert property (p_ovf) else $error("exponent overflow not flagged");
	property p_unf;
		(state == lfa_pkg::LFA_EXEC) && !dp_zero && !dp_fail && (dp_exp < lfa_pkg::EXP_MIN)
			|=> flags.fuf && flags.ovf && flags.trap1;
	endproperty
	a_unf: assert property (p_unf) else $error("exponent underflow not flagged");

	c_add: cover property ((state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_ADD_LONG) && !dp_lowclr);
	c_mul: cover property ((state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_MUL_LONG) && !dp_zero);
	c_div_ok: cover property ((state == lfa_pkg::LFA_EXEC) && (opl == lfa_pkg::OP_DIV_LONG) && !dp_fail && !dp_remclr);
	c_div_fail: cover property ((state == lfa_pkg::LFA_EXEC) && dp_fail);
endmodule : lfa_unit

// File: bench/lfa_seq_model.sv
// Sequencer model: AHB-Lite master issuing single word transfers
`timescale 1ns/10ps
module lfa_seq_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hrdata,
	output logic             o_hsel,
	output logic      [31:0] o_haddr,
	output logic      [1:0]  o_htrans,
	output logic             o_hwrite,
	output logic      [2:0]  o_hsize,
	output logic      [31:0] o_hwdata
);
	initial begin
		o_hsel   = 1'b0;
		o_haddr  = 32'h0;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize  = lfa_pkg::HSIZE_WORD;
		o_hwdata = 32'h0;
	end

	// Address held until hready sampled high
	task automatic addr_phase(input logic [31:0] addr, input logic wr);
		@(posedge i_sys_clk);
		o_hsel   <= 1'b1;
		o_haddr  <= addr;
		o_htrans <= lfa_pkg::HTRANS_NONSEQ;
		o_hwrite <= wr;
		do @(posedge i_sys_clk); while (i_hready !== 1'b1);
		o_hsel   <= 1'b0;
		// Stale address inverted so no slave can lean on it
		o_haddr  <= ~addr;
		o_htrans <= 2'h0;
	endtask : addr_phase

	task automatic write(input logic [31:0] addr, input logic [31:0] data);
		addr_phase(addr, 1'b1);
		o_hwdata <= data;
		do @(posedge i_sys_clk); while (i_hready !== 1'b1);
		o_hwdata <= ~data;
	endtask : write

	task automatic read(input logic [31:0] addr, output logic [31:0] data);
		addr_phase(addr, 1'b0);
		do @(posedge i_sys_clk); while (i_hready !== 1'b1);
		data = i_hrdata;
	endtask : read
endmodule : lfa_seq_model

// File: bench/tb_long_float_arith_unit.sv
// Self-checking bench for the long floating arithmetic unit
`timescale 1ns/10ps
module tb_long_float_arith_unit;
	localparam logic [8:0]  ADD = lfa_pkg::OP_ADD_LONG;
	localparam logic [8:0]  SUB = lfa_pkg::OP_SUB_LONG;
	localparam logic [8:0]  MUL = lfa_pkg::OP_MUL_LONG;
	localparam logic [8:0]  DIV = lfa_pkg::OP_DIV_LONG;
	localparam logic [31:0] PRI = lfa_pkg::ADDR_PRI_LO;
	localparam logic [31:0] NXT = lfa_pkg::ADDR_NXT_LO;
	localparam logic [31:0] MEM = lfa_pkg::ADDR_MEM_LO;

	logic        i_sys_clk = 1'b0;
	logic        i_reset   = 1'b1;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          num_errors  = 0;
	int          check_count = 0;

	always #2 i_sys_clk = ~i_sys_clk;

	lfa_unit dut (
		.i_sys_clk   (i_sys_clk),
		.i_reset     (i_reset),
		.i_hsel      (hsel),
		.i_haddr     (haddr),
		.i_htrans    (htrans),
		.i_hwrite    (hwrite),
		.i_hsize     (hsize),
		.i_hwdata    (hwdata),
		.i_hready    (hreadyout),
		.o_hrdata    (hrdata),
		.o_hreadyout (hreadyout),
		.o_hresp     (hresp)
	);

	lfa_seq_model seq (
		.i_sys_clk (i_sys_clk),
		.i_hready  (hreadyout),
		.i_hrdata  (hrdata),
		.o_hsel    (hsel),
		.o_haddr   (haddr),
		.o_htrans  (htrans),
		.o_hwrite  (hwrite),
		.o_hsize   (hsize),
		.o_hwdata  (hwdata)
	);

	task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] expv);
		check_count++;
		if (seen !== expv) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, expv, seen);
		end
	endtask : chk

	task automatic test_done();
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	// High half of a word sits at the next address
	task automatic put36(input logic [31:0] addr, input logic [35:0] w);
		seq.write(addr, w[31:0]);
		seq.write(addr + 32'h4, {28'h0, w[35:32]});
	endtask : put36

	task automatic get36(input logic [31:0] addr, output logic [35:0] w);
		logic [31:0] lo;
		logic [31:0] hi;
		seq.read(addr, lo);
		seq.read(addr + 32'h4, hi);
		w = {hi[3:0], lo};
	endtask : get36

	// Load operands, clear flags, start, then check results and flags
	task automatic run(input logic [8:0] op, input logic tw, input logic [35:0] pri, input logic [35:0] nxt,
			input logic [35:0] mem, input logic [35:0] epri, input logic [35:0] enxt, input logic [4:0] est,
			input logic cmp_nxt);
		logic [35:0] w;
		logic [31:0] r;
		put36(PRI, pri);
		put36(NXT, nxt);
		put36(MEM, mem);
		seq.write(lfa_pkg::ADDR_STAT, 32'h1f);
		seq.write(lfa_pkg::ADDR_CTRL, {21'h0, tw, 1'b1, op});
		get36(PRI, w);
		chk("primary_register", w, epri);
		if (cmp_nxt) begin
			get36(NXT, w);
			chk("next_register", w, enxt);
		end
		seq.read(lfa_pkg::ADDR_STAT, r);
		chk("status", {27'h0, r[8:0]}, {31'h0, est});
	endtask : run

	initial begin
		logic [31:0] r;
		repeat (5) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		// Every register clears on reset; the last address is unmapped
		for (int a = 0; a < 9; a++) begin
			seq.read(32'(a * 4), r);
			chk("reset_value", {4'h0, r}, 36'h0);
		end
		seq.write(32'h20, 32'hffffffff);
		seq.read(32'h20, r);
		chk("unmapped", {4'h0, r}, 36'h0);
		run(ADD, 0, 36'h40c000000, 36'h123456789, 36'h40c000000, 36'h414000000, 36'h0, 5'h00, 1);
		run(ADD, 0, 36'h40c000000, 36'h0, 36'h31c000000, 36'h40c000000, 36'h330800000, 5'h00, 1);
		run(ADD, 0, 36'h40c000000, 36'h0a5a5a5a5, 36'hbf4000000, 36'h0, 36'h0, 5'h00, 1);
		run(ADD, 0, 36'h0cc000001, 36'h123456789, 36'h0cc000000, 36'h0d4000000, 36'h0, 5'h00, 1);
		run(SUB, 0, 36'h40c000000, 36'h0, 36'hce4000000, 36'h40c000000, 36'h330800000, 5'h00, 1);
		run(SUB, 0, 36'h40c000000, 36'h0a5a5a5a5, 36'h40c000000, 36'h0, 36'h0, 5'h00, 1);
		run(MUL, 0, 36'h26c000001, 36'h0, 36'h274000001, 36'h0d4000002, 36'h0, 5'h00, 1);
		run(MUL, 0, 36'h274000001, 36'h0, 36'h274000001, 36'h0dc000002, 36'h000000002, 5'h00, 1);
		run(MUL, 0, 36'h674000001, 36'h0, 36'h66c000001, 36'h0d4000002, 36'h7f8000002, 5'h1c, 1);
		run(MUL, 0, 36'h674000001, 36'h0, 36'h674000001, 36'h0dc000002, 36'h0, 5'h1c, 1);
		run(MUL, 0, 36'h204000000, 36'h0, 36'h204000000, 36'h7fc000000, 36'h0, 5'h1e, 1);
		run(MUL, 0, 36'h40c000000, 36'h0a5a5a5a5, 36'h0, 36'h0, 36'h0, 5'h00, 1);
		run(DIV, 0, 36'h40c000000, 36'h330800000, 36'h402000000, 36'h40c000000, 36'h330800000, 5'h1d, 1);
		run(DIV, 0, 36'h40e000000, 36'h0, 36'h0, 36'h40e000000, 36'h0, 5'h1d, 1);
		run(DIV, 0, 36'h40c000000, 36'h0, 36'h40e000000, 36'h405555555, 36'h332000000, 5'h00, 1);
		run(DIV, 0, 36'h40e000000, 36'h0, 36'h40d000000, 36'h40ccccccc, 36'h33c000000, 5'h00, 1);
		run(DIV, 0, 36'h40c000000, 36'h334000000, 36'h40c000000, 36'h40c000000, 36'h33a000000, 5'h00, 1);
		run(DIV, 0, 36'h0d4000000, 36'h0, 36'h40e000000, 36'h0cd555555, 36'h0, 5'h00, 1);
		run(DIV, 0, 36'h40e000000, 36'h0, 36'h40c000000, 36'h40e000000, 36'h0, 5'h00, 1);
		run(DIV, 0, 36'hbf4000000, 36'h0, 36'h40e000000, 36'hbfaaaaaaa, 36'hcce000000, 5'h00, 1);
		run(DIV, 0, 36'hbf4000000, 36'h0, 36'h40c000000, 36'hbf4000000, 36'h0, 5'h00, 1);
		run(DIV, 1, 36'hbf4000000, 36'h0, 36'h40e000000, 36'hbfaaaaaab, 36'hcce000000, 5'h00, 1);
		seq.read(lfa_pkg::ADDR_CTRL, r);
		chk("control", {4'h0, r}, {25'h0, 1'b1, 1'b0, DIV});
		run(DIV, 0, 36'h408000000, 36'h000000001, 36'h40c000000, 36'h0, 36'h0, 5'h00, 0);
		// Unknown opcode leaves both registers alone
		run(9'h1ff, 0, 36'h40c000000, 36'h123456789, 36'h414000000, 36'h40c000000, 36'h123456789, 5'h00, 1);
		// Byte-sized writes are dropped
		seq.o_hsize <= 3'h0;
		seq.write(PRI, 32'hffffffff);
		seq.o_hsize <= lfa_pkg::HSIZE_WORD;
		seq.read(PRI, r);
		chk("narrow_write", {4'h0, r}, 36'h00c000000);
		chk("hresp", {35'h0, hresp}, {35'h0, lfa_pkg::HRESP_OKAY});
		chk("hreadyout", {35'h0, hreadyout}, 36'h1);
		test_done();
	end

	// Whole sequence needs under a thousand cycles
	initial begin
		#(4 * 20000);
		num_errors++;
		test_done();
	end
endmodule : tb_long_float_arith_unit
